// file: verilog/tpa_pkg.sv
// constants, register map and carrier types of the trace pulse parameter analyzer
package tpa_pkg;
  localparam int TW = 24;
  localparam int FRAC = 4;
  localparam int NPTS = 21;
  localparam int NIDX = 20;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_SETTINGS = 8'h04;
  localparam logic [7:0] OFF_PULSE_REF = 8'h08;
  localparam logic [7:0] OFF_TRAN_REF = 8'h0c;
  localparam logic [7:0] OFF_LOW_LEVEL = 8'h10;
  localparam logic [7:0] OFF_HIGH_LEVEL = 8'h14;
  localparam logic [7:0] OFF_QUERY = 8'h18;
  localparam logic [7:0] OFF_RESULT = 8'h1c;
  localparam logic [7:0] OFF_STATUS = 8'h20;
  localparam logic [7:0] OFF_COUNTS = 8'h24;
  localparam int CTRL_CAPTURE_BIT = 0;
  localparam int CTRL_UNIT_BIT = 1;
  localparam int CTRL_PRESET_BIT = 31;
  localparam int STAT_CLR_ERR_BIT = 31;
  localparam int STAT_CLR_DONE_BIT = 30;
  localparam logic [7:0] RST_PULSE_REF = 8'h32;
  localparam logic [7:0] RST_TRAN_LO = 8'h0a;
  localparam logic [7:0] RST_TRAN_HI = 8'h5a;
  localparam logic [7:0] PCT_FULL = 8'h64;
  localparam logic signed [7:0] PCT_MIN = -8'sd25;
  localparam logic signed [7:0] PCT_MAX = 8'sd125;
  localparam logic [15:0] ERR_NONE = 16'h0000;
  localparam logic [15:0] ERR_SETTINGS_CONFLICT = 16'hff23;
  localparam logic [15:0] ERR_OUT_OF_RANGE = 16'hff22;
  // ieee-754 single pattern of the out-of-range marker
  localparam logic [31:0] RESULT_SENTINEL = 32'h7e951bf0;
  typedef enum logic [2:0] {
    SRC_BUS = 3'b000,
    SRC_EXTERNAL = 3'b001,
    SRC_HOLD = 3'b010,
    SRC_IMMEDIATE = 3'b011,
    SRC_INTERNAL = 3'b100
  } tpa_trig_src_t;
  typedef enum logic [2:0] {
    Q_PULSE_DUR = 3'b000,
    Q_PULSE_PER = 3'b001,
    Q_PULSE_SEP = 3'b010,
    Q_NEG_DUR = 3'b011,
    Q_NEG_OCC = 3'b100,
    Q_POS_DUR = 3'b101,
    Q_POS_OCC = 3'b110,
    Q_REF_LEVEL = 3'b111
  } tpa_query_kind_t;
  typedef struct packed {
    logic list_on;
    logic average_only_detection;
    tpa_trig_src_t trigger_source_select;
    logic measurement_rate_select;
    logic free_run;
  } tpa_settings_t;
  typedef struct packed {
    logic [7:0] pct;
    tpa_query_kind_t kind;
    logic [4:0] index;
  } tpa_query_t;
  typedef struct packed {
    logic valid;
    logic trig;
    logic last;
    logic [15:0] power;
  } tpa_sample_t;
endpackage : tpa_pkg

// file: verilog/tpa_analyzer.sv
// trace pulse parameter analyzer: apb registers, crossing capture and query evaluation
//
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/1ps
module tpa_analyzer (
  input wire logic I_CLK, // 125 MHz clock
  input wire logic I_SRST, // synchronous reset, active high
  input wire logic I_PSEL, // apb select
  input wire logic I_PENABLE, // apb enable
  input wire logic I_PWRITE, // apb direction
  input wire logic [7:0] I_PADDR, // apb byte address
  input wire logic [31:0] I_PWDATA, // apb write data
  output logic [31:0] O_PRDATA, // apb read data
  output logic O_PREADY, // apb ready
  output logic O_PSLVERR, // apb error on unmapped address
  input wire tpa_pkg::tpa_sample_t I_SMP, // trace sample stream
  output logic O_CAPTURE_EN, // trace capture enabled
  output logic O_UNIT_W // trace unit is watts
);
  import tpa_pkg::*;

  typedef struct packed {
    logic [31:0] prdata;
    logic capture_en;
    logic unit_w;
    tpa_settings_t settings;
    logic [7:0] pulse_ref;
    logic [7:0] tran_lo;
    logic [7:0] tran_hi;
    logic [15:0] low_level;
    logic [15:0] high_level;
    logic [31:0] result;
    logic [15:0] err;
    logic list_conflict;
    logic done;
    logic in_cap;
    logic first_seen;
    logic first_pos;
    logic [19:0] k;
    logic [15:0] prev;
    logic [TW-1:0] trig_t;
    logic [TW-1:0] rise_lo_t;
    logic [TW-1:0] fall_hi_t;
    logic [4:0] pos_n;
    logic [4:0] neg_n;
    logic [4:0] pdur_n;
    logic [4:0] ndur_n;
    logic [NPTS-1:0][TW-1:0] pos_t;
    logic [NPTS-1:0][TW-1:0] neg_t;
    logic [NIDX-1:0][TW-1:0] pdur;
    logic [NIDX-1:0][TW-1:0] ndur;
  } tpa_state_t;

  tpa_state_t s_reg;
  tpa_state_t s_next;

  function automatic logic signed [31:0] ref_level(input logic [15:0] lo,
      input logic [15:0] hi, input logic signed [7:0] pct);
    logic signed [31:0] base;
    logic signed [31:0] span;
    base = $signed({16'h0000, lo});
    span = $signed({16'h0000, hi}) - base;
    ref_level = base + (span * 32'(pct)) / 32'sd100;
  endfunction : ref_level

  // instant of a crossing in sample k, with FRAC bits of linear interpolation
  function automatic logic [TW-1:0] cross_t(input logic [19:0] k,
      input logic signed [31:0] part, input logic signed [31:0] step);
    logic signed [31:0] frac;
    frac = (step > 32'sd0) ? (part <<< FRAC) / step : 32'sd0;
    cross_t = {k - 20'h00001, frac[FRAC-1:0]};
  endfunction : cross_t

  function automatic logic is_up(input logic signed [31:0] p, input logic signed [31:0] c,
      input logic signed [31:0] thr);
    is_up = (p < thr) && (c >= thr);
  endfunction : is_up

  function automatic logic [31:0] sext(input logic [TW-1:0] v);
    sext = {{(32 - TW){v[TW-1]}}, v};
  endfunction : sext

  function automatic logic hit(input logic [7:0] a);
    hit = (a == OFF_CTRL) || (a == OFF_SETTINGS) || (a == OFF_PULSE_REF) ||
          (a == OFF_TRAN_REF) || (a == OFF_LOW_LEVEL) || (a == OFF_HIGH_LEVEL) ||
          (a == OFF_QUERY) || (a == OFF_RESULT) || (a == OFF_STATUS) || (a == OFF_COUNTS);
  endfunction : hit

  logic setup;
  logic access;
  logic signed [31:0] lo_thr;
  logic signed [31:0] mid_thr;
  logic signed [31:0] hi_thr;
  logic signed [31:0] cur_s;
  logic signed [31:0] prev_s;
  tpa_query_t q;
  logic [4:0] qi;
  logic [4:0] qi1;
  logic q_idx_ok;

  assign setup = I_PSEL && !I_PENABLE;
  assign access = I_PSEL && I_PENABLE;
  assign lo_thr = ref_level(s_reg.low_level, s_reg.high_level, $signed(s_reg.tran_lo));
  assign hi_thr = ref_level(s_reg.low_level, s_reg.high_level, $signed(s_reg.tran_hi));
  assign mid_thr = ref_level(s_reg.low_level, s_reg.high_level, $signed(s_reg.pulse_ref));
  assign cur_s = $signed({16'h0000, I_SMP.power});
  assign prev_s = $signed({16'h0000, s_reg.prev});
  assign q = tpa_query_t'(I_PWDATA[15:0]);
  assign qi = q.index - 5'd1;
  assign qi1 = q.index;
  // indices outside 1 to 20 are answered with the marker
  assign q_idx_ok = (q.index != 5'd0) && (q.index <= 5'(NIDX));

  always_comb begin
    logic [TW-1:0] t_lo_up;
    logic [TW-1:0] t_lo_dn;
    logic [TW-1:0] t_mid_up;
    logic [TW-1:0] t_mid_dn;
    logic [TW-1:0] t_hi_up;
    logic [TW-1:0] t_hi_dn;
    logic ok;
    logic [TW-1:0] val;
    logic signed [31:0] rl;
    s_next = s_reg;
    ok = 1'b0;
    val = '0;
    rl = 32'sd0;
    t_lo_up = cross_t(s_reg.k, lo_thr - prev_s, cur_s - prev_s);
    t_lo_dn = cross_t(s_reg.k, prev_s - lo_thr, prev_s - cur_s);
    t_mid_up = cross_t(s_reg.k, mid_thr - prev_s, cur_s - prev_s);
    t_mid_dn = cross_t(s_reg.k, prev_s - mid_thr, prev_s - cur_s);
    t_hi_up = cross_t(s_reg.k, hi_thr - prev_s, cur_s - prev_s);
    t_hi_dn = cross_t(s_reg.k, prev_s - hi_thr, prev_s - cur_s);

    // read data is latched in the setup phase so pready can stay high
    if (setup && !I_PWRITE) begin
      case (I_PADDR)
        OFF_CTRL: s_next.prdata = {30'h0, s_reg.unit_w, s_reg.capture_en};
        OFF_SETTINGS: s_next.prdata = {25'h0, s_reg.settings};
        OFF_PULSE_REF: s_next.prdata = {24'h0, s_reg.pulse_ref};
        OFF_TRAN_REF: s_next.prdata = {16'h0, s_reg.tran_hi, s_reg.tran_lo};
        OFF_LOW_LEVEL: s_next.prdata = {16'h0, s_reg.low_level};
        OFF_HIGH_LEVEL: s_next.prdata = {16'h0, s_reg.high_level};
        OFF_RESULT: s_next.prdata = s_reg.result;
        OFF_STATUS: s_next.prdata = {12'h0, s_reg.in_cap, s_reg.first_pos, s_reg.done,
                                     s_reg.list_conflict, s_reg.err};
        OFF_COUNTS: s_next.prdata = {10'h0, s_reg.ndur_n, s_reg.pdur_n, 2'b00,
                                     s_reg.neg_n, s_reg.pos_n};
        default: s_next.prdata = 32'h0;
      endcase
    end

    // software clears come first so a hardware set in the same cycle wins
    if (access && I_PWRITE && I_PADDR == OFF_STATUS) begin
      if (I_PWDATA[STAT_CLR_ERR_BIT]) begin
        s_next.err = ERR_NONE;
        s_next.list_conflict = 1'b0;
      end
      if (I_PWDATA[STAT_CLR_DONE_BIT]) begin
        s_next.done = 1'b0;
      end
    end

    if (access && I_PWRITE) begin
      case (I_PADDR)
        OFF_CTRL: begin
          if (I_PWDATA[CTRL_PRESET_BIT]) begin
            s_next.capture_en = 1'b0;
            s_next.unit_w = 1'b0;
            s_next.pulse_ref = RST_PULSE_REF;
            s_next.tran_lo = RST_TRAN_LO;
            s_next.tran_hi = RST_TRAN_HI;
            s_next.in_cap = 1'b0;
          end else begin
            s_next.unit_w = I_PWDATA[CTRL_UNIT_BIT];
            if (!I_PWDATA[CTRL_CAPTURE_BIT]) begin
              s_next.capture_en = 1'b0;
              s_next.in_cap = 1'b0;
            end else if (s_reg.settings.list_on) begin
              s_next.err = ERR_SETTINGS_CONFLICT;
              s_next.list_conflict = 1'b1;
            end else if (s_reg.settings.average_only_detection) begin
              s_next.err = ERR_SETTINGS_CONFLICT;
            end else if (s_reg.settings.measurement_rate_select ||
                         !(s_reg.settings.trigger_source_select == SRC_INTERNAL ||
                           s_reg.settings.trigger_source_select == SRC_EXTERNAL)) begin
              s_next.err = ERR_SETTINGS_CONFLICT;
            end else begin
              s_next.capture_en = 1'b1;
            end
          end
        end
        OFF_SETTINGS: s_next.settings = tpa_settings_t'(I_PWDATA[6:0]);
        OFF_PULSE_REF: begin
          if (I_PWDATA[7:0] <= PCT_FULL) begin
            s_next.pulse_ref = I_PWDATA[7:0];
          end else begin
            s_next.err = ERR_OUT_OF_RANGE;
          end
        end
        OFF_TRAN_REF: begin
          if (I_PWDATA[7:0] <= PCT_FULL && I_PWDATA[15:8] <= PCT_FULL) begin
            s_next.tran_lo = I_PWDATA[7:0];
            s_next.tran_hi = I_PWDATA[15:8];
          end else begin
            s_next.err = ERR_OUT_OF_RANGE;
          end
        end
        OFF_LOW_LEVEL: s_next.low_level = I_PWDATA[15:0];
        OFF_HIGH_LEVEL: s_next.high_level = I_PWDATA[15:0];
        OFF_QUERY: begin
          if (s_reg.settings.free_run) begin
            s_next.err = ERR_SETTINGS_CONFLICT;
          end else begin
            case (q.kind)
              Q_PULSE_DUR: begin
                if (s_reg.first_pos) begin
                  ok = s_reg.pos_n > qi && s_reg.neg_n > qi;
                  val = s_reg.neg_t[qi] - s_reg.pos_t[qi];
                end else begin
                  ok = s_reg.pos_n > qi && s_reg.neg_n > qi1;
                  val = s_reg.neg_t[qi1] - s_reg.pos_t[qi];
                end
              end
              Q_PULSE_PER: begin
                if (s_reg.first_pos) begin
                  ok = s_reg.pos_n > qi1;
                  val = s_reg.pos_t[qi1] - s_reg.pos_t[qi];
                end else begin
                  ok = s_reg.neg_n > qi1;
                  val = s_reg.neg_t[qi1] - s_reg.neg_t[qi];
                end
              end
              Q_PULSE_SEP: begin
                if (s_reg.first_pos) begin
                  ok = s_reg.pos_n > qi1 && s_reg.neg_n > qi;
                  val = s_reg.pos_t[qi1] - s_reg.neg_t[qi];
                end else begin
                  ok = s_reg.pos_n > qi && s_reg.neg_n > qi;
                  val = s_reg.pos_t[qi] - s_reg.neg_t[qi];
                end
              end
              Q_NEG_DUR: begin
                ok = s_reg.ndur_n > qi;
                val = s_reg.ndur[qi];
              end
              Q_POS_DUR: begin
                ok = s_reg.pdur_n > qi;
                val = s_reg.pdur[qi];
              end
              Q_NEG_OCC: begin
                ok = s_reg.neg_n > qi;
                val = s_reg.neg_t[qi] - s_reg.trig_t;
              end
              Q_POS_OCC: begin
                ok = s_reg.pos_n > qi;
                val = s_reg.pos_t[qi] - s_reg.trig_t;
              end
              default: begin
                ok = 1'b0;
              end
            endcase
            if (q.kind == Q_REF_LEVEL) begin
              if ($signed(q.pct) >= PCT_MIN && $signed(q.pct) <= PCT_MAX) begin
                rl = ref_level(s_reg.low_level, s_reg.high_level, $signed(q.pct));
                s_next.result = rl;
              end else begin
                s_next.err = ERR_OUT_OF_RANGE;
              end
            end else if (ok && q_idx_ok && s_reg.first_seen) begin
              s_next.result = sext(val);
            end else begin
              s_next.result = RESULT_SENTINEL;
            end
          end
        end
        default: begin
          s_next.err = s_next.err;
        end
      endcase
    end

    // sample stream, crossings found per level and interpolated
    if (s_reg.capture_en && I_SMP.valid) begin
      if (!s_reg.in_cap) begin
        s_next.in_cap = 1'b1;
        s_next.k = 20'h00001;
        s_next.first_seen = 1'b0;
        s_next.first_pos = 1'b0;
        s_next.pos_n = 5'd0;
        s_next.neg_n = 5'd0;
        s_next.pdur_n = 5'd0;
        s_next.ndur_n = 5'd0;
        s_next.trig_t = '0;
        s_next.rise_lo_t = '0;
        s_next.fall_hi_t = '0;
        if (I_SMP.trig) begin
          s_next.trig_t = '0;
        end
      end else begin
        s_next.k = s_reg.k + 20'h00001;
        if (I_SMP.trig) begin
          s_next.trig_t = {s_reg.k, {FRAC{1'b0}}};
        end
        if (is_up(prev_s, cur_s, mid_thr)) begin
          if (!s_reg.first_seen) begin
            s_next.first_seen = 1'b1;
            s_next.first_pos = 1'b1;
          end
          if (s_reg.pos_n < 5'(NPTS)) begin
            s_next.pos_t[s_reg.pos_n] = t_mid_up;
            s_next.pos_n = s_reg.pos_n + 5'd1;
          end
        end
        // strict below on the way down, so a sample sitting on the level is not a fall
        if (prev_s >= mid_thr && cur_s < mid_thr) begin
          if (!s_reg.first_seen) begin
            s_next.first_seen = 1'b1;
            s_next.first_pos = 1'b0;
          end
          if (s_reg.neg_n < 5'(NPTS)) begin
            s_next.neg_t[s_reg.neg_n] = t_mid_dn;
            s_next.neg_n = s_reg.neg_n + 5'd1;
          end
        end
        // lower-level crossing opens a rise, upper-level crossing closes it
        if (is_up(prev_s, cur_s, lo_thr)) begin
          s_next.rise_lo_t = t_lo_up;
        end
        if (is_up(prev_s, cur_s, hi_thr) && s_reg.pdur_n < 5'(NIDX)) begin
          s_next.pdur[s_reg.pdur_n] =
            t_hi_up - (is_up(prev_s, cur_s, lo_thr) ? t_lo_up : s_reg.rise_lo_t);
          s_next.pdur_n = s_reg.pdur_n + 5'd1;
        end
        if (prev_s >= hi_thr && cur_s < hi_thr) begin
          s_next.fall_hi_t = t_hi_dn;
        end
        if (prev_s >= lo_thr && cur_s < lo_thr && s_reg.ndur_n < 5'(NIDX)) begin
          s_next.ndur[s_reg.ndur_n] =
            t_lo_dn - ((prev_s >= hi_thr && cur_s < hi_thr) ? t_hi_dn : s_reg.fall_hi_t);
          s_next.ndur_n = s_reg.ndur_n + 5'd1;
        end
      end
      s_next.prev = I_SMP.power;
      if (I_SMP.last) begin
        s_next.in_cap = 1'b0;
        s_next.done = 1'b1;
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      s_reg <= '0;
      s_reg.pulse_ref <= RST_PULSE_REF;
      s_reg.tran_lo <= RST_TRAN_LO;
      s_reg.tran_hi <= RST_TRAN_HI;
      s_reg.settings.trigger_source_select <= SRC_INTERNAL;
    end else begin
      s_reg <= s_next;
    end
  end

  assign O_PRDATA = s_reg.prdata;
  assign O_PREADY = 1'b1;
  assign O_PSLVERR = access && !hit(I_PADDR);
  assign O_CAPTURE_EN = s_reg.capture_en;
  assign O_UNIT_W = s_reg.unit_w;
endmodule : tpa_analyzer

// file: sim/tpa_analyzer_props.sv
// port-level assertions of the trace pulse parameter analyzer
`timescale 1ns/1ps
module tpa_analyzer_props
  import tpa_pkg::*;
(
  input wire logic I_CLK, // clock
  input wire logic I_SRST, // synchronous reset
  input wire logic I_PSEL, // apb select
  input wire logic I_PENABLE, // apb enable
  input wire logic I_PWRITE, // apb direction
  input wire logic [7:0] I_PADDR, // apb address
  input wire logic [31:0] I_PWDATA, // apb write data
  input wire logic [31:0] O_PRDATA, // apb read data
  input wire logic O_PREADY, // apb ready
  input wire logic O_PSLVERR, // apb error
  input wire logic O_CAPTURE_EN, // capture enabled
  input wire logic O_UNIT_W // unit is watts
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SRST);
  logic acc;
  logic bad_addr;
  logic ctrl_wr;
  assign acc = I_PSEL && I_PENABLE;
  assign bad_addr = (I_PADDR[1:0] != 2'b00) || (I_PADDR > OFF_COUNTS);
  assign ctrl_wr = acc && I_PWRITE && (I_PADDR == OFF_CTRL);
  property p_ready;
    O_PREADY;
  endproperty
  a_ready: assert property (p_ready) else $error("ready dropped");
  property p_slverr;
    O_PSLVERR == (acc && bad_addr);
  endproperty
  a_slverr: assert property (p_slverr) else $error("slave error wrong");
  property p_bad_rd;
    acc && !I_PWRITE && bad_addr |-> O_PRDATA == 32'h0;
  endproperty
  a_bad_rd: assert property (p_bad_rd) else $error("unmapped read not zero");
  property p_rst;
    $fell(I_SRST) |-> !O_CAPTURE_EN && !O_UNIT_W;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_cap_off;
    ctrl_wr && !I_PWDATA[CTRL_CAPTURE_BIT] |=> !O_CAPTURE_EN;
  endproperty
  a_cap_off: assert property (p_cap_off) else $error("capture not off");
  property p_unit;
    ctrl_wr && !I_PWDATA[CTRL_PRESET_BIT] |=> O_UNIT_W == $past(I_PWDATA[CTRL_UNIT_BIT]);
  endproperty
  a_unit: assert property (p_unit) else $error("unit not written");
  property p_preset;
    ctrl_wr && I_PWDATA[CTRL_PRESET_BIT] |=> !O_CAPTURE_EN ##0 !O_UNIT_W;
  endproperty
  a_preset: assert property (p_preset) else $error("preset state wrong");
  property p_cap_hold;
    !ctrl_wr |=> $stable(O_CAPTURE_EN);
  endproperty
  a_cap_hold: assert property (p_cap_hold) else $error("capture changed alone");
  property p_rd_ctrl;
    acc && !I_PWRITE && I_PADDR == OFF_CTRL |-> O_PRDATA[1:0] == {O_UNIT_W, O_CAPTURE_EN};
  endproperty
  a_rd_ctrl: assert property (p_rd_ctrl) else $error("state readback wrong");
  c_cap_on: cover property (ctrl_wr ##1 O_CAPTURE_EN);
  c_slverr: cover property (O_PSLVERR);
  c_unit: cover property ($rose(O_UNIT_W));
endmodule : tpa_analyzer_props
bind tpa_analyzer tpa_analyzer_props u_tpa_analyzer_props (.I_CLK(I_CLK), .I_SRST(I_SRST),
  .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR),
  .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
  .O_CAPTURE_EN(O_CAPTURE_EN), .O_UNIT_W(O_UNIT_W));

// file: sim/tpa_trace_src.sv
// sample source playing one short pulse train into the analyzer
`timescale 1ns/1ps
module tpa_trace_src (
  input wire logic i_clk, // bench clock
  input wire logic i_start, // starts one capture
  output tpa_pkg::tpa_sample_t o_smp // sample stream
);
  import tpa_pkg::*;
  logic [15:0] pw_tab [7];
  int pos_reg = 7;
  initial pw_tab = '{16'h0000, 16'h00a0, 16'h00a0, 16'h0000, 16'h0000, 16'h00a0, 16'h0000};
  // capture ends with last before queries
  always @(posedge i_clk) begin
    if (i_start) begin
      pos_reg = 0;
    end
    if (pos_reg < 7) begin
      o_smp <= '{valid: 1'b1, trig: pos_reg == 1, last: pos_reg == 6, power: pw_tab[pos_reg]};
      pos_reg = pos_reg + 1;
    end else begin
      // idle bus parked at all ones, far from any threshold
      o_smp <= '{valid: 1'b0, trig: 1'b0, last: 1'b0, power: 16'hffff};
    end
  end
endmodule : tpa_trace_src

// file: sim/testbench.sv
// self-checking bench of the trace pulse parameter analyzer
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_errors++; \
  $display("ERROR %0t got %h exp %h", $time, a, b); end end
module testbench;
  import tpa_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic start = 1'b0;
  tpa_sample_t smp;
  logic cap_en;
  logic unit_w;
  logic [31:0] rd;
  logic err_seen;
  int n_errors = 0;
  int cmp_count = 0;
  always #4 clk = ~clk;
  tpa_analyzer u_tpa_analyzer (.I_CLK(clk), .I_SRST(srst), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .I_SMP(smp), .O_CAPTURE_EN(cap_en),
    .O_UNIT_W(unit_w));
  tpa_trace_src u_tpa_trace_src (.i_clk(clk), .i_start(start), .o_smp(smp));
  task automatic end_of_test();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) begin
      n_errors++;
      end_of_test();
    end
  endtask : apb
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    `CHK(rd, exp)
  endtask : rdchk
  task automatic qchk(input tpa_query_kind_t k, input logic [4:0] i, input logic [7:0] p,
    input logic [31:0] exp);
    tpa_query_t q;
    q = '{pct: p, kind: k, index: i};
    apb(1'b1, OFF_QUERY, {16'h0000, q});
    rdchk(OFF_RESULT, exp);
  endtask : qchk
  task automatic stchk(input logic [16:0] exp);
    apb(1'b0, OFF_STATUS, 32'h0);
    `CHK(rd[16:0], exp)
    apb(1'b1, OFF_STATUS, 32'h80000000);
  endtask : stchk
  task automatic t_defaults();
    rdchk(OFF_CTRL, 32'h0);
    rdchk(OFF_PULSE_REF, 32'h32);
    rdchk(OFF_TRAN_REF, 32'h5a0a);
  endtask : t_defaults
  task automatic t_conflicts();
    logic [31:0] cfg [6] = '{32'h50, 32'h30, 32'h12, 32'h00, 32'h08, 32'h0c};
    apb(1'b1, OFF_STATUS, 32'h80000000);
    foreach (cfg[i]) begin
      apb(1'b1, OFF_SETTINGS, cfg[i]);
      apb(1'b1, OFF_CTRL, 32'h1);
      rdchk(OFF_CTRL, 32'h0);
      stchk({i == 0, ERR_SETTINGS_CONFLICT});
    end
    apb(1'b1, OFF_SETTINGS, 32'h04);
    apb(1'b1, OFF_CTRL, 32'h1);
    rdchk(OFF_CTRL, 32'h1);
    `CHK(cap_en, 1'b1)
    apb(1'b1, OFF_CTRL, 32'h0);
    rdchk(OFF_CTRL, 32'h0);
  endtask : t_conflicts
  task automatic t_capture();
    int n;
    apb(1'b1, OFF_SETTINGS, 32'h10);
    apb(1'b1, OFF_LOW_LEVEL, 32'h0);
    apb(1'b1, OFF_HIGH_LEVEL, 32'h64);
    apb(1'b1, OFF_CTRL, 32'h1);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    n = 0;
    do begin
      apb(1'b0, OFF_STATUS, 32'h0);
      n++;
    end while (rd[17] !== 1'b1 && n < 20);
    `CHK(rd[17], 1'b1)
    if (rd[17] !== 1'b1) begin
      end_of_test();
    end
    rdchk(OFF_COUNTS, 32'h00042042);
    qchk(Q_PULSE_DUR, 5'd1, 8'h0, 32'd38);
    qchk(Q_PULSE_PER, 5'd1, 8'h0, 32'd64);
    qchk(Q_PULSE_SEP, 5'd1, 8'h0, 32'd26);
    qchk(Q_PULSE_DUR, 5'd2, 8'h0, 32'd22);
    qchk(Q_PULSE_PER, 5'd2, 8'h0, RESULT_SENTINEL);
    qchk(Q_PULSE_DUR, 5'd3, 8'h0, RESULT_SENTINEL);
    qchk(Q_POS_DUR, 5'd1, 8'h0, 32'd8);
    qchk(Q_NEG_DUR, 5'd1, 8'h0, 32'd8);
    qchk(Q_POS_OCC, 5'd1, 8'h0, 32'hfffffff5);
    qchk(Q_NEG_OCC, 5'd1, 8'h0, 32'd27);
    qchk(Q_POS_OCC, 5'd20, 8'h0, RESULT_SENTINEL);
  endtask : t_capture
  task automatic t_ref_level();
    apb(1'b1, OFF_LOW_LEVEL, 32'h14);
    apb(1'b1, OFF_HIGH_LEVEL, 32'h78);
    qchk(Q_REF_LEVEL, 5'd1, 8'd25, 32'd45);
    qchk(Q_REF_LEVEL, 5'd1, 8'd125, 32'd145);
    qchk(Q_REF_LEVEL, 5'd1, 8'he7, 32'hfffffffb);
    qchk(Q_REF_LEVEL, 5'd1, 8'd126, 32'hfffffffb);
    stchk({1'b0, ERR_OUT_OF_RANGE});
  endtask : t_ref_level
  task automatic t_free_run();
    apb(1'b1, OFF_SETTINGS, 32'h11);
    qchk(Q_PULSE_DUR, 5'd1, 8'h0, 32'hfffffffb);
    stchk({1'b0, ERR_SETTINGS_CONFLICT});
    qchk(Q_REF_LEVEL, 5'd1, 8'd25, 32'hfffffffb);
    stchk({1'b0, ERR_SETTINGS_CONFLICT});
    apb(1'b1, OFF_SETTINGS, 32'h10);
  endtask : t_free_run
  task automatic t_preset();
    apb(1'b1, OFF_CTRL, 32'h3);
    @(posedge clk);
    `CHK(unit_w, 1'b1)
    rdchk(OFF_CTRL, 32'h3);
    apb(1'b1, OFF_PULSE_REF, 32'h19);
    apb(1'b1, OFF_PULSE_REF, 32'h65);
    rdchk(OFF_PULSE_REF, 32'h19);
    apb(1'b1, OFF_CTRL, 32'h80000000);
    rdchk(OFF_CTRL, 32'h0);
    rdchk(OFF_PULSE_REF, 32'h32);
    qchk(Q_PULSE_DUR, 5'd1, 8'h0, 32'd38);
  endtask : t_preset
  task automatic t_unmapped_reset();
    apb(1'b0, 8'h40, 32'h0);
    `CHK({err_seen, rd}, {1'b1, 32'h0})
    apb(1'b1, OFF_TRAN_REF, 32'h4b05);
    rdchk(OFF_TRAN_REF, 32'h4b05);
    apb(1'b1, OFF_CTRL, 32'h3);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    `CHK({cap_en, unit_w}, 2'b00)
    rdchk(OFF_TRAN_REF, 32'h5a0a);
  endtask : t_unmapped_reset
  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    t_defaults();
    t_conflicts();
    t_capture();
    t_ref_level();
    t_free_run();
    t_preset();
    t_unmapped_reset();
    end_of_test();
  end
endmodule : testbench
